// *** ors_sequencer.sv ***
// Momentary outage restart sequencer with AHB-Lite settings registers
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ors_sequencer
    import ors_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Power stage status
    input  wire logic        running,
    input  wire logic        bus_below_uv,
    input  wire logic        bus_below_restart_limit,
    input  wire logic        charge_done,
    input  wire logic        current_limit_active,
    input  wire logic [15:0] output_freq,
    // Commands
    input  wire logic        forward_run_cmd,
    input  wire logic        reverse_run_cmd,
    input  wire logic        keypad_run,
    input  wire logic        coast_stop_cmd,
    // Decisions
    output logic             restart_mode_active,
    output logic             output_shutdown,
    output logic             uv_alarm,
    output logic             restart_go,
    output logic             normal_start_req,
    output logic             restart_dir_rev,
    output logic [15:0]      freq_cmd,
    output logic             fall_use_decel,
    output logic             fall_use_pi,
    output logic             fall_step
);
    // Settings registers, captured frequency and direction, and sequencer state
    logic [9:0]  mode_reg;
    logic [15:0] allowable_outage_time;
    logic [15:0] restart_delay;
    logic [15:0] freq_fall_rate;
    logic [15:0] start_freq;
    logic [15:0] saved_freq;
    logic        restart_dir_saved;
    ors_state_e  state;
    ors_state_e  next_state;

    logic [2:0] restart_mode_select;
    logic [1:0] run_source_select;
    logic       inst_overcurrent_limit_en;
    assign restart_mode_select       = mode_reg[MODE_SEL_LSB +: 3];
    assign run_source_select         = mode_reg[RUN_SRC_LSB +: 2];
    assign inst_overcurrent_limit_en = mode_reg[OC_LIM_BIT];

    // AHB-Lite address phase capture
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_addr;
    logic       take;
    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;   // Zero wait states
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_rd   <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr   <= take && hwrite;
            ph_rd   <= take && !hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    // Read data registered during the address phase would miss writes; decode in data phase
    always_comb begin
        hrdata = 32'h0000_0000;
        if (!ph_rd) begin
            hrdata = 32'h0000_0000;
        end else if (ph_addr == OFS_MODE) begin
            hrdata = {22'h00_0000, mode_reg};
        end else if (ph_addr == OFS_OUTAGE) begin
            hrdata = {16'h0000, allowable_outage_time};
        end else if (ph_addr == OFS_DELAY) begin
            hrdata = {16'h0000, restart_delay};
        end else if (ph_addr == OFS_FALL) begin
            hrdata = {16'h0000, freq_fall_rate};
        end else if (ph_addr == OFS_STATUS) begin
            hrdata = {24'h00_0000, restart_dir_saved, state};
        end else if (ph_addr == OFS_FREQ) begin
            hrdata = {16'h0000, saved_freq};
        end else if (ph_addr == OFS_START_FREQ) begin
            hrdata = {16'h0000, start_freq};
        end
    end

    // Out-of-range outage time and fall rate writes are clamped to the legal span
    function automatic logic [15:0] clamp_outage(input logic [15:0] v);
        if (v == OUTAGE_UNTIL_LOW) begin
            clamp_outage = v;
        end else if (v > OUTAGE_MAX) begin
            clamp_outage = OUTAGE_MAX;
        end else begin
            clamp_outage = v;
        end
    endfunction

    function automatic logic [15:0] clamp_fall(input logic [15:0] v);
        if (v == FALL_PI) begin
            clamp_fall = v;
        end else if (v > FALL_MAX) begin
            clamp_fall = FALL_MAX;
        end else begin
            clamp_fall = v;
        end
    endfunction

    // Settings writes; restart delay default follows the capacity class
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg              <= MODE_RESET;
            allowable_outage_time <= 16'h0000;
            restart_delay         <= DELAY_SMALL;
            freq_fall_rate        <= FALL_DECEL;
            start_freq            <= START_FREQ_RST;
        end else if (ph_wr) begin
            if (ph_addr == OFS_MODE) begin
                mode_reg <= hwdata[9:0];
                if (hwdata[BIG_CLASS_BIT] != mode_reg[BIG_CLASS_BIT]) begin
                    restart_delay <= hwdata[BIG_CLASS_BIT] ? DELAY_BIG : DELAY_SMALL;
                end
            end else if (ph_addr == OFS_OUTAGE) begin
                allowable_outage_time <= clamp_outage(hwdata[15:0]);
            end else if (ph_addr == OFS_DELAY) begin
                restart_delay <= hwdata[15:0];
            end else if (ph_addr == OFS_FALL) begin
                freq_fall_rate <= clamp_fall(hwdata[15:0]);
            end else if (ph_addr == OFS_START_FREQ) begin
                start_freq <= hwdata[15:0];
            end
        end
    end

    // Timebase and the three timers
    logic tick;
    logic tmr_clear;
    logic outage_done;
    logic delay_done;
    logic wait_done;
    logic restart_mode;
    logic outage_timed;

    assign restart_mode = (state == ORS_OUTAGE) || (state == ORS_CHARGE) ||
                          (state == ORS_READY);
    assign outage_timed = allowable_outage_time != OUTAGE_UNTIL_LOW;

    ors_tick_div u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    ors_ms_timer u_outage (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (tmr_clear),
        .run     (restart_mode && outage_timed),
        .tick    (tick),
        .limit   (20'(allowable_outage_time) * 20'(TENTH_MS)),
        .done    (outage_done)
    );

    ors_ms_timer u_delay (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (tmr_clear),
        .run     (restart_mode),
        .tick    (tick),
        .limit   (20'(restart_delay) * 20'(TENTH_MS)),
        .done    (delay_done)
    );

    ors_ms_timer u_wait (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (tmr_clear),
        .run     (state == ORS_READY),
        .tick    (tick),
        .limit   (20'(RUN_WAIT_TICKS)),
        .done    (wait_done)
    );

    // Conditions shared by the state machine
    logic run_any;
    logic fixed_dir;
    logic outage_lost;
    logic outage_start;
    assign run_any      = forward_run_cmd || reverse_run_cmd || keypad_run;
    assign fixed_dir    = run_source_select[1];
    assign outage_start = running && bus_below_uv;
    assign outage_lost  = outage_timed ? outage_done
                                       : bus_below_restart_limit;
    assign tmr_clear    = (next_state != state) &&
                          (state == ORS_RUN_IDLE || !(next_state inside {ORS_CHARGE, ORS_READY}));

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ORS_RUN_IDLE: begin
                if (outage_start) begin
                    if (restart_mode_select == MODE_SAVED_FREQ ||
                        restart_mode_select == MODE_START_FREQ) begin
                        next_state = ORS_OUTAGE;
                    end else begin
                        next_state = ORS_TRIP;
                    end
                end
            end
            ORS_OUTAGE: begin
                if (coast_stop_cmd || outage_lost) begin
                    next_state = ORS_NORMAL;
                end else if (!bus_below_uv) begin
                    next_state = ORS_CHARGE;
                end
            end
            ORS_CHARGE: begin
                if (coast_stop_cmd || outage_lost) begin
                    next_state = ORS_NORMAL;
                end else if (charge_done) begin
                    next_state = ORS_READY;
                end
            end
            ORS_READY: begin
                if (coast_stop_cmd || outage_lost) begin
                    next_state = ORS_NORMAL;
                end else if ((run_any || fixed_dir) && delay_done) begin
                    next_state = ORS_RESTART;
                end else if (wait_done && !fixed_dir) begin
                    next_state = ORS_NORMAL;
                end
            end
            ORS_RESTART: begin
                next_state = ORS_RUN_IDLE;
            end
            ORS_TRIP: begin
                if (!running && !bus_below_uv && !run_any && uv_alarm) begin
                    next_state = ORS_RUN_IDLE;
                end
            end
            ORS_NORMAL: begin
                if (!run_any) begin
                    next_state = ORS_RUN_IDLE;
                end
            end
            default: begin
                next_state = ORS_RUN_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ORS_RUN_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Frequency and direction caught at the instant of failure
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            saved_freq        <= 16'h0000;
            restart_dir_saved <= 1'b0;
        end else if (state == ORS_RUN_IDLE && outage_start) begin
            saved_freq        <= output_freq;
            restart_dir_saved <= reverse_run_cmd && !forward_run_cmd;
        end
    end

    // Trip alarm; mode 1 raises it only once power is back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uv_alarm <= 1'b0;
        end else if (next_state == ORS_TRIP) begin
            uv_alarm <= (restart_mode_select == MODE_TRIP) || !bus_below_uv;
        end else begin
            uv_alarm <= 1'b0;
        end
    end

    // Restart decision outputs, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_go       <= 1'b0;
            normal_start_req <= 1'b0;
            restart_dir_rev  <= 1'b0;
            freq_cmd         <= 16'h0000;
        end else begin
            restart_go       <= next_state == ORS_RESTART;
            normal_start_req <= (next_state == ORS_NORMAL) && (state != ORS_NORMAL);
            if (next_state == ORS_RESTART) begin
                restart_dir_rev <= fixed_dir ? restart_dir_saved : reverse_run_cmd;
                freq_cmd <= (restart_mode_select == MODE_SAVED_FREQ) ?
                            saved_freq : start_freq;
            end
        end
    end

    // Output shutdown while in restart mode or tripped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_mode_active <= 1'b0;
            output_shutdown     <= 1'b0;
        end else begin
            restart_mode_active <= next_state inside {ORS_OUTAGE, ORS_CHARGE, ORS_READY};
            output_shutdown     <= next_state inside {ORS_OUTAGE, ORS_CHARGE, ORS_READY,
                                                      ORS_TRIP};
        end
    end

    // Fall-rate selection; only with the fast limiter enabled
    logic fall_active;
    assign fall_active = current_limit_active && inst_overcurrent_limit_en;
    assign fall_use_decel = fall_active && (freq_fall_rate == FALL_DECEL);
    assign fall_use_pi    = fall_active && (freq_fall_rate == FALL_PI);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fall_step <= 1'b0;
        end else begin
            fall_step <= fall_active && tick && !fall_use_decel && !fall_use_pi;
        end
    end
endmodule // ors_sequencer

// *** ors_pkg.sv ***
// Shared constants, register map and types of the outage restart sequencer
package ors_pkg;

    // Clock and timebase
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    // Time settings held in 0.1 s units, 100 ticks of 1 ms per unit
    localparam int unsigned TENTH_MS        = 100;
    localparam int unsigned RUN_WAIT_MS     = 2000;
    localparam logic [15:0] RUN_WAIT_TICKS  = 16'(RUN_WAIT_MS / TICK_MS);

    // Register byte offsets
    localparam logic [7:0] OFS_MODE         = 8'h00;
    localparam logic [7:0] OFS_OUTAGE       = 8'h04;
    localparam logic [7:0] OFS_DELAY        = 8'h08;
    localparam logic [7:0] OFS_FALL         = 8'h0C;
    localparam logic [7:0] OFS_STATUS       = 8'h10;
    localparam logic [7:0] OFS_FREQ         = 8'h14;
    localparam logic [7:0] OFS_START_FREQ   = 8'h18;

    // Mode register fields
    localparam int unsigned MODE_SEL_LSB    = 0;  // restart_mode_select, 3 bits
    localparam int unsigned RUN_SRC_LSB     = 4;  // run_source_select, 2 bits
    localparam int unsigned OC_LIM_BIT      = 8;  // inst_overcurrent_limit_en
    localparam int unsigned BIG_CLASS_BIT   = 9;  // Capacity 11 to 15 kW

    // Encodings and special values
    localparam logic [2:0]  MODE_TRIP       = 3'h0;
    localparam logic [2:0]  MODE_TRIP_REC   = 3'h1;
    localparam logic [2:0]  MODE_SAVED_FREQ = 3'h4;
    localparam logic [2:0]  MODE_START_FREQ = 3'h5;
    localparam logic [15:0] OUTAGE_MAX      = 16'h012C;  // 30.0 s in 0.1 s
    localparam logic [15:0] OUTAGE_UNTIL_LOW = 16'h03E7; // 999
    localparam logic [15:0] FALL_DECEL      = 16'h0000;
    localparam logic [15:0] FALL_MAX        = 16'h2710;  // 100.00 Hz/s
    localparam logic [15:0] FALL_PI         = 16'h03E7;  // 999 selects PI
    localparam logic [15:0] DELAY_SMALL     = 16'h0005;  // 0.5 s
    localparam logic [15:0] DELAY_BIG       = 16'h000A;  // 1.0 s
    localparam logic [9:0]  MODE_RESET      = 10'h000;
    localparam logic [15:0] START_FREQ_RST  = 16'h0032;

    // Sequencer states
    typedef enum logic [6:0] {
        ORS_RUN_IDLE = 7'b000_0001,
        ORS_OUTAGE   = 7'b000_0010,
        ORS_CHARGE   = 7'b000_0100,
        ORS_READY    = 7'b000_1000,
        ORS_RESTART  = 7'b001_0000,
        ORS_TRIP     = 7'b010_0000,
        ORS_NORMAL   = 7'b100_0000
    } ors_state_e;

endpackage : ors_pkg

// *** ors_tick_div.sv ***
// One-millisecond timebase enable
`timescale 1ns/1ps
module ors_tick_div
    import ors_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Enable out
    output logic      tick
);
    logic [13:0] count;

    // Free running divider, one pulse each period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 14'h0000;
            tick  <= 1'b0;
        end else if (count == 14'(TICK_CYCLES - 1)) begin
            count <= 14'h0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 14'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // ors_tick_div

// *** ors_ms_timer.sv ***
// Millisecond counter with clear, compare and done flag
`timescale 1ns/1ps
module ors_ms_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Control
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic [19:0] limit,
    // Status
    output logic             done
);
    logic [19:0] count;

    // Counts ticks while run, saturates at the limit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 20'h0_0000;
            done  <= 1'b0;
        end else if (clear) begin
            count <= 20'h0_0000;
            done  <= 1'b0;
        end else if (run && tick && !done) begin
            count <= count + 20'h0_0001;
            done  <= (count + 20'h0_0001) >= limit;
        end
    end
endmodule // ors_ms_timer

// *** ors_seq_props.sv ***
// Assertion checker for the outage restart sequencer ports
`timescale 1ns/1ps
module ors_seq_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Power stage and commands
    input wire logic running,
    input wire logic bus_below_uv,
    input wire logic coast_stop_cmd,
    // Decisions
    input wire logic restart_mode_active,
    input wire logic output_shutdown,
    input wire logic uv_alarm,
    input wire logic restart_go,
    input wire logic normal_start_req,
    input wire logic fall_use_decel,
    input wire logic fall_use_pi
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Entry into restart mode needs a running drive and a sagging bus
    chk_fail_entry: assert property ($rose(restart_mode_active) |-> $past(running && bus_below_uv))
        else $error("restart mode entered without a running undervoltage");
    chk_fail_shut: assert property ($rose(restart_mode_active) |-> output_shutdown)
        else $error("restart mode without output shutdown");
    chk_go_pulse: assert property (restart_go |=> !restart_go)
        else $error("restart decision longer than one cycle");
    chk_go_power: assert property (restart_go |-> !bus_below_uv)
        else $error("restart issued while bus still low");
    chk_coast_exit: assert property (coast_stop_cmd && restart_mode_active |-> ##[1:4] !restart_mode_active)
        else $error("coast stop did not leave restart mode");
    chk_norm_pulse: assert property (normal_start_req |=> !normal_start_req)
        else $error("normal start request longer than one cycle");
    chk_alarm_shut: assert property (uv_alarm |-> output_shutdown)
        else $error("alarm with output still live");
    chk_fall_excl: assert property (!(fall_use_decel && fall_use_pi))
        else $error("two fall methods at once");

    // Main scenarios reached
    cover property (restart_go);
    cover property (normal_start_req);
    cover property ($rose(uv_alarm));
endmodule // ors_seq_props

bind ors_sequencer ors_seq_props u_props (.hclk, .hresetn, .running, .bus_below_uv,
    .coast_stop_cmd, .restart_mode_active, .output_shutdown, .uv_alarm, .restart_go,
    .normal_start_req, .fall_use_decel, .fall_use_pi);

// *** ors_power_stage.sv ***
// Behavioural power stage partner of the sequencer
`timescale 1ns/1ps
module ors_power_stage #(
    parameter int unsigned CHARGE_CYC = 20
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Scenario controls
    input  wire logic        supply_ok,
    input  wire logic        motor_on,
    input  wire logic        deep_loss,
    input  wire logic [15:0] set_freq,
    // From the sequencer
    input  wire logic        output_shutdown,
    input  wire logic        restart_go,
    // To the sequencer
    output logic             running,
    output logic             bus_below_uv,
    output logic             bus_below_restart_limit,
    output logic             charge_done,
    output logic             current_limit_active,
    output logic [15:0]      output_freq
);
    logic [7:0] chg_cnt;
    logic [3:0] lim_cnt;

    // Comparators follow the supply at once
    assign bus_below_uv = !supply_ok;
    assign bus_below_restart_limit = deep_loss && !supply_ok;
    assign running = motor_on && !output_shutdown;
    assign output_freq = set_freq;
    assign charge_done = (chg_cnt == 8'(CHARGE_CYC));
    assign current_limit_active = (lim_cnt != 4'h0);

    // Charge restarts from zero on every dip, as the capacitors would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chg_cnt <= 8'h00;
        end else if (!supply_ok) begin
            chg_cnt <= 8'h00;
        end else if (!charge_done) begin
            chg_cnt <= chg_cnt + 8'h01;
        end
    end

    // Coasting motor lags the restart frequency, so the limiter acts briefly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lim_cnt <= 4'h0;
        end else if (restart_go) begin
            lim_cnt <= 4'h8;
        end else if (current_limit_active) begin
            lim_cnt <= lim_cnt - 4'h1;
        end
    end
endmodule // ors_power_stage

// *** outage_restart_sequencer_tb_top.sv ***
// Self-checking testbench for the outage restart sequencer
`timescale 1ns/1ps
module outage_restart_sequencer_tb_top;
    import ors_pkg::*;
    logic        hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        running, bus_below_uv, bus_below_restart_limit, charge_done;
    logic        current_limit_active, forward_run_cmd, reverse_run_cmd, keypad_run;
    logic        coast_stop_cmd, restart_mode_active, output_shutdown, uv_alarm;
    logic        restart_go, normal_start_req, restart_dir_rev, fall_use_decel;
    logic        fall_use_pi, fall_step, supply_ok, motor_on, deep_loss;
    logic [15:0] output_freq, freq_cmd, set_freq;
    int          fails, cmp_count;

    // Single hclk at 10 MHz
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    ors_sequencer dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .running, .bus_below_uv,
        .bus_below_restart_limit, .charge_done, .current_limit_active, .output_freq,
        .forward_run_cmd, .reverse_run_cmd, .keypad_run, .coast_stop_cmd,
        .restart_mode_active, .output_shutdown, .uv_alarm, .restart_go, .normal_start_req,
        .restart_dir_rev, .freq_cmd, .fall_use_decel, .fall_use_pi, .fall_step);

    ors_power_stage u_stage (.hclk, .hresetn, .supply_ok, .motor_on, .deep_loss, .set_freq,
        .output_shutdown, .restart_go, .running, .bus_below_uv, .bus_below_restart_limit,
        .charge_done, .current_limit_active, .output_freq);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Bounded wait for hready at a rising edge
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            check("hready", 32'h0000_0001, 32'(hreadyout));
            end_of_test();
        end
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rdv);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= wd;
        bus_wait();
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0000_0000, x);
        check(what, exp, x);
    endtask

    // Wait on restart_go (0), normal_start_req (1) or uv_alarm (2)
    task automatic wait_hi(input int sel, input int lim);
        int   n;
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
            s = (sel == 0) ? restart_go : (sel == 1) ? normal_start_req : uv_alarm;
        end
        if (s !== 1'b1) begin
            check("awaited output", 32'h0000_0001, 32'(s));
            end_of_test();
        end
    endtask

    // Fresh reset, then mode word and outage time; zero delay keeps runs short
    task automatic setup(input logic [31:0] mode, input logic [31:0] outage_t);
        hresetn <= 1'b0;
        {supply_ok, motor_on} <= 2'h3;
        {deep_loss, coast_stop_cmd, forward_run_cmd, reverse_run_cmd} <= 4'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(OFS_MODE, mode);
        wr(OFS_OUTAGE, outage_t);
        wr(OFS_DELAY, 32'h0000_0000);
    endtask

    task automatic outage(input logic restore, input logic exp_active);
        supply_ok <= 1'b0;
        repeat (10) @(posedge hclk);
        check("restart mode", 32'(exp_active), 32'(restart_mode_active));
        if (restore) begin
            supply_ok <= 1'b1;
        end
    endtask

    initial begin
        {hwrite, haddr, hwdata, htrans, keypad_run} = '0;
        hsize = 3'h2;
        set_freq = 16'h1234;
        hresetn = 1'b0;
        fails = 0;
        cmp_count = 0;
        setup(32'h0000_0000, 32'h0000_0000);
        rd_chk("start freq reset", OFS_START_FREQ, 32'(START_FREQ_RST));
        rd_chk("status idle", OFS_STATUS, 32'h0000_0001);
        wr(OFS_MODE, 32'h0000_0200);
        rd_chk("delay big", OFS_DELAY, 32'(DELAY_BIG));
        wr(OFS_MODE, 32'h0000_0000);
        rd_chk("delay small", OFS_DELAY, 32'(DELAY_SMALL));
        wr(OFS_OUTAGE, 32'h0000_01F4);
        rd_chk("outage clamp", OFS_OUTAGE, 32'(OUTAGE_MAX));
        wr(OFS_FALL, 32'h0000_4E20);
        rd_chk("fall clamp", OFS_FALL, 32'(FALL_MAX));
        wr(8'h1C, 32'h0000_5A5A);
        rd_chk("unmapped", 8'h1C, 32'h0000_0000);
        $display("test registers done");
        // Saved-frequency restart, forward then reverse run command
        for (int i = 0; i < 2; i++) begin
            setup(32'h0000_0104, 32'(OUTAGE_UNTIL_LOW));
            outage(1'b1, 1'b1);
            repeat (40) @(posedge hclk);
            rd_chk("status ready", OFS_STATUS, 32'h0000_0008);
            forward_run_cmd <= (i == 0);
            reverse_run_cmd <= (i == 1);
            wait_hi(0, 20000);
            check("saved freq", 32'(set_freq), 32'(freq_cmd));
            check("direction", 32'(i), 32'(restart_dir_rev));
            rd_chk("saved freq reg", OFS_FREQ, 32'(set_freq));
        end
        $display("test saved frequency done");
        // Fixed direction restarts with no run command
        for (int i = 2; i < 4; i++) begin
            setup(32'h0000_0105 | 32'(i << 4), 32'(OUTAGE_UNTIL_LOW));
            wr(OFS_FALL, 32'(FALL_PI));
            outage(1'b1, 1'b1);
            wait_hi(0, 20000);
            check("start freq", 32'(START_FREQ_RST), 32'(freq_cmd));
            repeat (2) @(posedge hclk);
            check("pi fall", 32'h0000_0001, 32'(fall_use_pi));
        end
        $display("test fixed direction done");
        setup(32'h0000_0000, 32'(OUTAGE_UNTIL_LOW));
        outage(1'b0, 1'b0);
        wait_hi(2, 20);
        setup(32'h0000_0001, 32'(OUTAGE_UNTIL_LOW));
        outage(1'b1, 1'b0);
        check("alarm held", 32'h0000_0000, 32'(uv_alarm));
        wait_hi(2, 100);
        $display("test trip modes done");
        setup(32'h0000_0004, 32'(OUTAGE_UNTIL_LOW));
        motor_on <= 1'b0;
        @(posedge hclk);
        outage(1'b1, 1'b0);
        rd_chk("status idle", OFS_STATUS, 32'h0000_0001);
        setup(32'h0000_0004, 32'(OUTAGE_UNTIL_LOW));
        outage(1'b0, 1'b1);
        coast_stop_cmd <= 1'b1;
        wait_hi(1, 50);
        check("coast exit", 32'h0000_0000, 32'(restart_mode_active));
        setup(32'h0000_0004, 32'(OUTAGE_UNTIL_LOW));
        outage(1'b0, 1'b1);
        deep_loss <= 1'b1;
        wait_hi(1, 50);
        setup(32'h0000_0004, 32'h0000_0000);
        outage(1'b1, 1'b1);
        wait_hi(1, 20000);
        $display("test cancel paths done");
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge hclk);
        check("run length", 32'h0000_0000, 32'h0000_0001);
        end_of_test();
    end
endmodule // outage_restart_sequencer_tb_top
